// [verilog/cca_pkg.sv]
// Purpose: Shared constants and carrier types for the central channel arbiter.
// Assumes: A 40 MHz system clock and an 8-bit arbitration register on the I/O port.
// Notes: Every offset, field position, register field reset value and timing count is named here once.
package cca_pkg;

  // Clock period of the system clock in picoseconds (40 MHz).
  localparam int CLK_PERIOD_PS = 25000;

  // I/O address of the arbitration register.
  localparam logic [15:0] ARB_REG_ADDR = 16'h0090;

  // Field positions of the arbitration register.
  localparam int BIT_CPU_EN = 7;
  localparam int BIT_MASK = 6;
  localparam int BIT_EXT_TOUT = 5;
  localparam int BIT_RSVD = 4;

  // Reset values of the register fields.
  localparam logic RST_CPU_EN = 1'b0;
  localparam logic RST_MASK = 1'b0;
  localparam logic RST_EXT = 1'b0;
  localparam logic RST_TOUT = 1'b0;

  // Arbitration levels: system processor is the lowest priority.
  localparam logic [3:0] LVL_CPU = 4'hF;
  localparam logic [3:0] RST_DMA0_LVL = 4'h0;
  localparam logic [3:0] RST_DMA4_LVL = 4'h4;

  // Burst time-out, a longest time, so the cycle count rounds down.
  localparam int TOUT_NS = 7800;
  localparam int TOUT_CYC = (TOUT_NS * 1000) / CLK_PERIOD_PS;

  // Minimum arbitration cycle, a least time, so the cycle counts round up.
  localparam int ARB_MIN_NS = 375;
  localparam int ARB_EXT_NS = 750;
  localparam int ARB_MIN_CYC = (ARB_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ARB_EXT_CYC = (ARB_EXT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Cycles at the start of a grant phase in which the channel lines are not trusted yet.
  localparam int GRANT_SETTLE_CYC = 6;

  // Width of the shared time counter.
  localparam int CNT_W = 10;

  // Controller states, one-hot.
  typedef enum logic [4:0] {
    ST_GRANT = 5'b00001,
    ST_WAIT_EOT = 5'b00010,
    ST_ARB = 5'b00100,
    ST_INTERNAL = 5'b01000,
    ST_MASKED = 5'b10000
  } cca_state_type;

  // Channel inputs that arrive from the pins, all active low except the level bus.
  typedef struct packed {
    logic request_n;
    logic burst_n;
    logic cmd_n;
    logic status0_n;
    logic status1_n;
    logic [3:0] priority_bus;
  } cca_chan_type;

  // Reset value of the channel inputs: everything idle, bus floating high.
  localparam cca_chan_type CHAN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF};

endpackage

// [verilog/cca_arbiter.sv]
// Purpose: Central arbitration point for the shared expansion channel.
// Assumes: Channel pins are asynchronous; the I/O port strobes are on clk.
// Notes: Open-collector request is split into in, out and enable.
`timescale 1ns/1ps

module cca_arbiter #(
  parameter int ADDR_W = 16
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Channel pins.
  input wire logic channel_request_n_in,
  output logic channel_request_n_out,
  output logic channel_request_n_oe,
  input wire logic burst_n,
  input wire logic cmd_n,
  input wire logic cycle_status0_n,
  input wire logic cycle_status1_n,
  input wire logic [3:0] priority_bus,
  output logic arbitrate_grant_phase,
  // Internal system-board requesters.
  input wire logic refresh_req,
  input wire logic nmi_req,
  output logic refresh_grant,
  output logic nmi_grant,
  output logic nmi,
  output logic cpu_grant,
  output logic [3:0] owner_level,
  // DMA level programming for channels 0 and 4.
  input wire logic dma_level_load,
  input wire logic [3:0] dma0_level_in,
  input wire logic [3:0] dma4_level_in,
  output logic [3:0] dma0_level,
  output logic [3:0] dma4_level,
  // Processor I/O port.
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);

  // The port decode compares against a 16-bit address; narrower buses cannot reach it.
  if (ADDR_W < 16)
  begin : g_bad_addr
    $error("cca_arbiter: ADDR_W must be at least 16");
  end

  // Three-stage synchroniser; only stages two and three are looked at.
  cca_pkg::cca_chan_type raw;
  cca_pkg::cca_chan_type sync1, sync2, sync3, chan;
  cca_pkg::cca_chan_type next_chan;

  assign raw = '{channel_request_n_in, burst_n, cmd_n, cycle_status0_n, cycle_status1_n, priority_bus};

  // A bit of the filtered copy follows only once stages two and three agree.
  always_comb
  begin
    next_chan = chan;
    for (int i = 0; i < $bits(cca_pkg::cca_chan_type); i++)
    begin
      if (sync2[i] == sync3[i])
      begin
        next_chan[i] = sync2[i];
      end
    end
  end

  // Synchroniser and filter registers.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= cca_pkg::CHAN_IDLE;
      sync2 <= cca_pkg::CHAN_IDLE;
      sync3 <= cca_pkg::CHAN_IDLE;
      chan <= cca_pkg::CHAN_IDLE;
    end
    else if (ce)
    begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      chan <= next_chan;
    end
  end

  // Returns the minimum arbitration length in cycles for the chosen mode.
  function automatic logic [cca_pkg::CNT_W-1:0] arb_len(input logic ext);
    arb_len = ext ? cca_pkg::CNT_W'(cca_pkg::ARB_EXT_CYC) : cca_pkg::CNT_W'(cca_pkg::ARB_MIN_CYC);
  endfunction

  // Controller state and register fields.
  cca_pkg::cca_state_type state, next_state;
  logic [cca_pkg::CNT_W-1:0] cnt, next_cnt;
  logic cpu_en, next_cpu_en;
  logic mask, next_mask;
  logic ext_arb, next_ext_arb;
  logic tout, next_tout;
  logic [3:0] last_level, next_last_level;
  logic next_req_oe, next_arb_phase, next_refresh_grant, next_nmi_grant, next_nmi, next_cpu_grant;
  logic [3:0] next_owner_level, next_dma0_level, next_dma4_level;
  logic [7:0] next_rdata;
  logic eot, req_seen, hit, serving_nmi, next_serving_nmi, settled;

  // End of transfer: both status lines idle and the later of burst and strobe idle.
  assign eot = chan.status0_n & chan.status1_n & chan.burst_n & chan.cmd_n;
  // Request seen from the channel (another party or our own drive).
  assign req_seen = ~chan.request_n;
  assign hit = (io_addr[15:0] == cca_pkg::ARB_REG_ADDR);
  // The new owner's request release and first burst reach us late through the synchroniser.
  // Acting on them earlier would see a stale request and steal the grant back at once.
  assign settled = (cnt >= cca_pkg::CNT_W'(cca_pkg::GRANT_SETTLE_CYC));

  // Next-state logic for the controller, the register and all outputs but channel_request_n_out.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_cpu_en = cpu_en;
    next_mask = mask;
    next_ext_arb = ext_arb;
    next_tout = tout;
    next_last_level = last_level;
    next_owner_level = owner_level;
    next_serving_nmi = serving_nmi;
    next_nmi = nmi;
    next_dma0_level = dma0_level;
    next_dma4_level = dma4_level;
    next_refresh_grant = 1'b0;
    next_nmi_grant = 1'b0;
    next_req_oe = 1'b0;
    // DMA channels 0 and 4 may be moved to any level; the rest are fixed.
    if (dma_level_load)
    begin
      next_dma0_level = dma0_level_in;
      next_dma4_level = dma4_level_in;
    end
    // Register write; bits 3-0 are ignored on a write.
    if (io_wr && hit)
    begin
      next_cpu_en = io_wdata[cca_pkg::BIT_CPU_EN];
      next_ext_arb = io_wdata[cca_pkg::BIT_EXT_TOUT];
      next_mask = io_wdata[cca_pkg::BIT_MASK];
      if (!io_wdata[cca_pkg::BIT_MASK])
      begin
        next_tout = 1'b0;
        next_nmi = 1'b0;
      end
    end
    case (state)
      cca_pkg::ST_GRANT:
      begin
        // Internal requesters pull the shared request line themselves.
        next_req_oe = refresh_req | nmi_req;
        if (refresh_req || nmi_req || (settled && req_seen))
        begin
          next_state = cca_pkg::ST_WAIT_EOT;
          next_cnt = '0;
        end
        else if (settled && eot && owner_level != cca_pkg::LVL_CPU)
        begin
          // The owner is done and nobody waits, so the processor gets the channel back.
          next_cnt = '0;
          next_state = cca_pkg::ST_ARB;
        end
        else if (!settled)
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      cca_pkg::ST_WAIT_EOT:
      begin
        next_req_oe = refresh_req | nmi_req;
        if (!chan.burst_n && cnt >= cca_pkg::CNT_W'(cca_pkg::TOUT_CYC))
        begin
          // Owner held burst too long: take the channel away at once.
          next_tout = 1'b1;
          next_mask = 1'b1;
          next_nmi = 1'b1;
          next_state = cca_pkg::ST_MASKED;
        end
        else if (eot)
        begin
          next_cnt = '0;
          // Refresh (-2) outranks NMI (-1); both outrank every channel level.
          if (refresh_req || nmi_req)
          begin
            next_serving_nmi = ~refresh_req;
            next_state = cca_pkg::ST_INTERNAL;
          end
          else
          begin
            next_state = cca_pkg::ST_ARB;
          end
        end
        else if (!chan.burst_n)
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      cca_pkg::ST_INTERNAL:
      begin
        // Served only while the phase line stays at arbitrate.
        next_refresh_grant = ~serving_nmi & refresh_req;
        next_nmi_grant = serving_nmi & nmi_req;
        if ((serving_nmi && !nmi_req) || (!serving_nmi && !refresh_req))
        begin
          next_refresh_grant = 1'b0;
          next_nmi_grant = 1'b0;
          next_cnt = '0;
          next_state = cca_pkg::ST_ARB;
        end
      end
      cca_pkg::ST_ARB:
      begin
        // Hold arbitrate for the minimum cycle, then latch the winning level.
        if (cnt + 1'b1 >= arb_len(ext_arb))
        begin
          next_owner_level = req_seen ? chan.priority_bus : cca_pkg::LVL_CPU;
          next_last_level = next_owner_level;
          next_cnt = '0;
          next_state = cca_pkg::ST_GRANT;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      cca_pkg::ST_MASKED:
      begin
        // Processor owns the channel until software clears the mask.
        next_owner_level = cca_pkg::LVL_CPU;
        if (!mask)
        begin
          next_cnt = '0;
          next_state = cca_pkg::ST_ARB;
        end
      end
      default:
      begin
        next_state = cca_pkg::ST_ARB;
        next_cnt = '0;
      end
    endcase
    // A set mask overrides every state; the time-out path already enters ST_MASKED itself.
    if (next_mask && next_state != cca_pkg::ST_MASKED)
    begin
      next_state = cca_pkg::ST_MASKED;
      next_refresh_grant = 1'b0;
      next_nmi_grant = 1'b0;
    end
    // The owner keeps its grant while it winds down; only end of transfer, a time-out or a mask write raises the line.
    next_arb_phase = (next_state != cca_pkg::ST_GRANT) && (next_state != cca_pkg::ST_WAIT_EOT);
    next_cpu_grant = (next_state == cca_pkg::ST_MASKED)
      || ((next_state == cca_pkg::ST_GRANT || next_state == cca_pkg::ST_WAIT_EOT)
      && next_owner_level == cca_pkg::LVL_CPU)
      || (next_state == cca_pkg::ST_ARB && cpu_en);
    // Read data: bit 4 is always zero.
    next_rdata = 8'h00;
    if (io_rd && hit)
    begin
      next_rdata = {cpu_en, mask, tout, 1'b0, last_level};
    end
  end

  // Registers for the controller, the arbitration register and every output but channel_request_n_out.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= cca_pkg::ST_ARB;
      cnt <= '0;
      cpu_en <= cca_pkg::RST_CPU_EN;
      mask <= cca_pkg::RST_MASK;
      ext_arb <= cca_pkg::RST_EXT;
      tout <= cca_pkg::RST_TOUT;
      last_level <= cca_pkg::LVL_CPU;
      owner_level <= cca_pkg::LVL_CPU;
      serving_nmi <= 1'b0;
      nmi <= 1'b0;
      dma0_level <= cca_pkg::RST_DMA0_LVL;
      dma4_level <= cca_pkg::RST_DMA4_LVL;
      channel_request_n_oe <= 1'b0;
      arbitrate_grant_phase <= 1'b1;
      refresh_grant <= 1'b0;
      nmi_grant <= 1'b0;
      cpu_grant <= 1'b0;
      io_rdata <= 8'h00;
    end
    else if (ce)
    begin
      state <= next_state;
      cnt <= next_cnt;
      cpu_en <= next_cpu_en;
      mask <= next_mask;
      ext_arb <= next_ext_arb;
      tout <= next_tout;
      last_level <= next_last_level;
      owner_level <= next_owner_level;
      serving_nmi <= next_serving_nmi;
      nmi <= next_nmi;
      dma0_level <= next_dma0_level;
      dma4_level <= next_dma4_level;
      channel_request_n_oe <= next_req_oe;
      arbitrate_grant_phase <= next_arb_phase;
      refresh_grant <= next_refresh_grant;
      nmi_grant <= next_nmi_grant;
      cpu_grant <= next_cpu_grant;
      io_rdata <= next_rdata;
    end
  end

  // The open-collector line only ever pulls low.
  always_ff @(posedge clk)
  begin
    channel_request_n_out <= 1'b0;
  end

endmodule

// [sim/cca_arbiter_chk.sv]
// Purpose: Port assertions for the central channel arbiter.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound into every arbiter instance.
`timescale 1ns/1ps
module cca_arbiter_chk #(
  parameter int ADDR_W = 16
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic arbitrate_grant_phase,
  input wire logic nmi,
  input wire logic cpu_grant,
  input wire logic refresh_grant,
  input wire logic nmi_grant,
  input wire logic dma_level_load,
  input wire logic [3:0] dma0_level_in,
  input wire logic [3:0] dma0_level,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  logic hit; // Register access taken this edge.
  logic [5:0] arb_len; // Cycles in the present arbitrate phase, saturating.
  logic [5:0] next_arb_len;
  assign hit = ce && io_addr == cca_pkg::ARB_REG_ADDR;
  // Saturation keeps long masked periods from wrapping back to a short count.
  always_comb
  begin
    next_arb_len = (sys_rst || !arbitrate_grant_phase) ? 6'h00 : arb_len + {5'h00, arb_len != 6'h3F};
  end
  always_ff @(posedge clk)
  begin
    arb_len <= next_arb_len;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  read_zero_a: assert property (hit && io_rd |=> io_rdata[4] == 1'b0)
    else $error("reserved bit read as one");
  read_miss_a: assert property (ce && io_rd && !hit |=> io_rdata == 8'h00)
    else $error("unmapped read returned data");
  mask_force_a: assert property (hit && io_wr && io_wdata[6] |=> arbitrate_grant_phase && cpu_grant)
    else $error("mask write did not force processor arbitration");
  masked_hold_a: assert property (nmi |-> arbitrate_grant_phase)
    else $error("grant issued while masked");
  tout_read_a: assert property (nmi && hit && io_rd |=> io_rdata[6:5] == 2'b11)
    else $error("time-out flags missing on read");
  unmask_a: assert property (nmi && hit && io_wr && !io_wdata[6] |=> !nmi)
    else $error("unmask write left interrupt set");
  arb_min_a: assert property ($fell(arbitrate_grant_phase) |-> arb_len >= 6'(cca_pkg::ARB_MIN_CYC))
    else $error("arbitration cycle too short");
  internal_a: assert property (refresh_grant || nmi_grant |-> arbitrate_grant_phase)
    else $error("internal level served in grant phase");
  dma_load_a: assert property (ce && dma_level_load |=> dma0_level == $past(dma0_level_in))
    else $error("level load not taken");
  cover property ($rose(nmi));
  cover property ($fell(arbitrate_grant_phase));
  cover property (nmi_grant);
endmodule
bind cca_arbiter cca_arbiter_chk #(.ADDR_W(ADDR_W)) chk (.*);

// [sim/cca_adapter_model.sv]
// Purpose: Behavioural local arbiter of one adapter.
// Assumes: Open-collector lines are resolved by the bench with pull-ups.
// Notes: A stubborn adapter ignores preemption so a time-out can be provoked.
`timescale 1ns/1ps
module cca_adapter_model (
  input wire logic clk,
  input wire logic go,
  input wire logic stubborn,
  input wire logic [15:0] hold,
  input wire logic [3:0] lvl,
  input wire logic request_n,
  input wire logic arbitrate_grant_phase,
  input wire logic [3:0] priority_bus,
  output logic req_oe,
  output logic compete,
  output logic burst_n,
  output logic cmd_n
);
  logic won; // Bus showed our level at the end of arbitration.
  assign compete = req_oe && arbitrate_grant_phase; // Level driven only while arbitrating.
  // One request per go pulse, repeated arbitration until the channel is won.
  initial
  begin
    {req_oe, won} = 2'b00;
    {burst_n, cmd_n} = 2'b11;
    forever
    begin
      @(posedge clk iff go);
      @(negedge clk);
      req_oe = 1'b1;
      won = 1'b0;
      while (!won)
      begin
        @(negedge clk iff arbitrate_grant_phase);
        while (arbitrate_grant_phase)
        begin
          won = priority_bus == lvl;
          @(negedge clk);
        end
      end
      req_oe = 1'b0;
      burst_n = 1'b0;
      for (int i = 0; i < hold && (stubborn || request_n); i++)
      begin
        cmd_n = i[0];
        @(negedge clk);
      end
      {burst_n, cmd_n} = 2'b11;
      // Fairness: a preempted owner sits out until the request line goes inactive.
      while (!request_n)
      begin
        @(negedge clk);
      end
    end
  end
endmodule

// [sim/central_channel_arbiter_tb.sv]
// Purpose: Self-checking bench for the central channel arbiter.
// Assumes: Inputs change on the falling edge; ce stays high except for one frozen cycle near the end.
// Notes: Two adapter models compete on the wired channel lines.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module central_channel_arbiter_tb;
  logic clk, sys_rst, oe, out, phase, rgnt, ngnt, nmi, cpug, rreq, nreq, ld, rd, wr, ce;
  logic [3:0] own, d0, d4, pbus, d0i, d4i;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] go, st, oe_m, cmp, bn, cn;
  logic [15:0] hold [2];
  logic [3:0] lv [2] = '{4'h5, 4'hA}; // Both above level 1, so no diskette hold-off bound applies.
  int bad_count, checks_done, cyc;
  wire req_n = !(oe && !out) && !(|oe_m);
  // Settled value of the bit-serial wired-AND contest: the lower level survives.
  assign pbus = (cmp[0] && (!cmp[1] || lv[0] < lv[1])) ? lv[0] : cmp[1] ? lv[1] : 4'hF;
  cca_arbiter dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .channel_request_n_in(req_n), .channel_request_n_out(out),
    .channel_request_n_oe(oe), .burst_n(&bn), .cmd_n(&cn), .cycle_status0_n(&cn), .cycle_status1_n(&cn),
    .priority_bus(pbus), .arbitrate_grant_phase(phase), .refresh_req(rreq), .nmi_req(nreq), .refresh_grant(rgnt),
    .nmi_grant(ngnt), .nmi(nmi), .cpu_grant(cpug), .owner_level(own), .dma_level_load(ld), .dma0_level_in(d0i),
    .dma4_level_in(d4i), .dma0_level(d0), .dma4_level(d4), .io_addr(addr), .io_rd(rd), .io_wr(wr), .io_wdata(wdata),
    .io_rdata(rdata));
  for (genvar k = 0; k < 2; k++)
  begin : g_m
    cca_adapter_model m (.clk(clk), .go(go[k]), .stubborn(st[k]), .hold(hold[k]), .lvl(lv[k]), .request_n(req_n),
      .arbitrate_grant_phase(phase), .priority_bus(pbus), .req_oe(oe_m[k]), .compete(cmp[k]), .burst_n(bn[k]),
      .cmd_n(cn[k]));
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, far above the longest scenario.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One register cycle; read data stands in the cycle after the read edge.
  task automatic acc(input logic w, input logic [7:0] d, input logic [15:0] a = cca_pkg::ARB_REG_ADDR);
    @(negedge clk);
    {wr, rd} = {w, !w};
    addr = a;
    wdata = d;
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  task automatic wait_phase(input logic v, output int n);
    n = 0;
    while (phase !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("phase", v, phase)
  endtask
  task automatic request(input logic [1:0] g);
    go = g;
    @(negedge clk);
    go = 2'b00;
  endtask
  initial
  begin
    int n;
    {rreq, nreq, ld, rd, wr, go, st, addr, wdata, d0i, d4i, bad_count, checks_done, cyc} = '0;
    hold = '{16'd8, 16'd8};
    ce = 1'b1;
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    `CHK("dma0", cca_pkg::RST_DMA0_LVL, d0)
    `CHK("dma4", cca_pkg::RST_DMA4_LVL, d4)
    acc(1'b0, 8'h00);
    `CHK("reset read", 8'h0F, rdata)
    acc(1'b0, 8'h00, 16'h0091);
    `CHK("unmapped", 8'h00, rdata)
    acc(1'b1, 8'hBF);
    acc(1'b0, 8'h00);
    `CHK("ctl read", 8'h8F, rdata)
    request(2'b11);
    wait_phase(1'b1, n);
    @(negedge clk);
    `CHK("cpu in arb", 1'b1, cpug)
    wait_phase(1'b0, n);
    `CHK("owner", 4'h5, own)
    acc(1'b0, 8'h00);
    `CHK("last level", 8'h85, rdata)
    wait_phase(1'b1, n);
    wait_phase(1'b0, n);
    `CHK("ext arb", 1'b1, n >= cca_pkg::ARB_EXT_CYC)
    `CHK("next owner", 4'hA, own)
    wait_phase(1'b1, n);
    wait_phase(1'b0, n);
    `CHK("idle owner", cca_pkg::LVL_CPU, own)
    acc(1'b1, 8'h00);
    st = 2'b01;
    hold = '{16'd400, 16'd4};
    request(2'b01);
    wait_phase(1'b1, n);
    wait_phase(1'b0, n);
    request(2'b10);
    wait_phase(1'b1, n);
    `CHK("tout time", 1'b1, n >= cca_pkg::TOUT_CYC && n <= cca_pkg::TOUT_CYC + 10)
    @(negedge clk);
    `CHK("nmi", 1'b1, nmi)
    `CHK("cpu masked", 1'b1, cpug)
    acc(1'b0, 8'h00);
    `CHK("tout read", 8'h65, rdata)
    repeat (50) @(negedge clk);
    `CHK("still masked", 1'b1, phase)
    acc(1'b1, 8'h00);
    `CHK("nmi clear", 1'b0, nmi)
    acc(1'b0, 8'h00);
    `CHK("flags clear", 3'b000, rdata[7:5])
    wait_phase(1'b0, n);
    repeat (20) @(negedge clk);
    acc(1'b1, 8'h40);
    `CHK("forced", 2'b11, {phase, cpug})
    acc(1'b1, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      {nreq, rreq} = 2'b01 << i;
      n = 0;
      while (!(rgnt || ngnt) && n < 500)
      begin
        @(negedge clk);
        n++;
      end
      `CHK("internal", {nreq, rreq, 1'b1}, {ngnt, rgnt, phase})
      {nreq, rreq} = 2'b00;
      repeat (60) @(negedge clk);
    end
    {ce, ld, d0i, d4i} = {1'b0, 1'b1, 4'h9, 4'h2};
    @(negedge clk);
    `CHK("frozen", 8'h04, {d0, d4})
    ce = 1'b1;
    @(negedge clk);
    ld = 1'b0;
    `CHK("dma load", 8'h92, {d0, d4})
    end_of_test();
  end
endmodule
